// File: rtl/pp_consts.svh
// constants for the parallel port pin control block
// assumes an 8-bit register port with a 7-bit address
`ifndef PP_CONSTS_SVH
`define PP_CONSTS_SVH

// port slots: 0=P0 1=P1 2=P2 3=P4 4=P7 5=P8 6=P9 7=PB
`define PP_NPORT        8
`define PP_TOTAL_PINS   40
// per-port masks, slot 7 in the top byte
`define PP_WIDTH_MASKS  64'h0f03_03ff_ffff_0f0f
`define PP_FE_MASKS     64'h0f03_03ff_ffff_0005
`define PP_OTYPE_MASKS  64'h0f03_0000_00ff_0000
// address map: addr[5:3] port slot, addr[2:0] register kind
`define PP_REG_LATCH    3'h0
`define PP_REG_PINRD    3'h1
`define PP_REG_DIR      3'h2
`define PP_REG_FE       3'h3
`define PP_REG_OTYPE    3'h4
`define PP_REG_PULLUP   3'h5
`define PP_ADDR_SERCFG  7'h40
// serial config field positions
`define PP_SER_FUNC_LO  0
`define PP_SER_FUNC_HI  1
`define PP_SER_LOC      2
`define PP_SER_SWAP     3
`define PP_SER_MASK     8'h0f
`define PP_RESET_BYTE   8'h00
// pin positions
`define PP_SLOT_P0      3'h0
`define PP_SLOT_P1      3'h1
`define PP_SLOT_P2      3'h2
`define PP_BIT_SLOWOSC  2
`define PP_BIT_FASTOSC  0

`endif

// File: rtl/pp_pkg.sv
// types shared by the parallel port pin control block
// assumes the constants header is included by users
package pp_pkg;
	typedef logic [7:0][7:0] pp_ports_t;

	// secondary outputs of on-chip peripherals towards the pins
	typedef struct packed {
		logic sclkOut;
		logic sclkDrv;
		logic soOut;
		logic uartTx;
		logic sclOut;
		logic sdaOut;
	} pp_sec_out_t;

	// pin levels handed to the on-chip peripherals
	typedef struct packed {
		logic sclkIn;
		logic siIn;
		logic uartRx;
		logic sclIn;
		logic sdaIn;
		logic irqA;
		logic irqB;
		logic irqC;
		logic stopRelease;
		logic resetPin;
	} pp_sec_in_t;
endpackage

// File: rtl/pp_port_ctrl.sv
// parallel port pin control: latches, direction, function routing
// assumes pins arrive asynchronously and a tristate pad cell outside
//
// Overview of operation
// RULE1 - eight ports, forty pins, each port two to eight pins wide
// RULE2 - output latch keeps last written value until next write
// RULE3 - input path unlatched, read returns live pin level
// RULE4 - pins sampled in the read cycle, no hardware filtering
// RULE5 - written value reaches pin in cycle after the write
// RULE6 - output mode drives the pin from the output latch
// RULE7 - pin read register returns present input pin levels
// RULE8 - direction bit: 0 input, 1 output
// RULE9 - function enable 1 routes peripheral output, 0 uses latch
// RULE10 - output type bit selects push-pull or low-only open drain
// RULE11 - pull-up only in input mode or open drain output
// RULE12 - port 0 pins double as fast and slow oscillator pins
// RULE13 - fast oscillator pins never act as general purpose pins
// RULE14 - port 1 feeds reset, three interrupts, stop release
// RULE15 - port 2 routed by serial function select field
// RULE16 - uart swap picks tx/rx pin while location select is 0
// RULE17 - after reset all pins inputs with secondary output off
//
// Decided for this implementation: the register offsets and strobed register access.
`include "pp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pp_port_ctrl (
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic [6:0]        regAddr,
	input  wire logic [7:0]        regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [7:0]        regRdata,
	input  wire pp_pkg::pp_ports_t padIn,
	output pp_pkg::pp_ports_t      padOut,
	output pp_pkg::pp_ports_t      padOe,
	output pp_pkg::pp_ports_t      padPu,
	input  wire pp_pkg::pp_sec_out_t secOut,
	output pp_pkg::pp_sec_in_t     secIn,
	output logic                   fastOscEn,
	output logic                   slowOscEn
);

	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] slotMask(input logic [63:0] m, input logic [2:0] s);
		slotMask = m[s*8 +: 8];
	endfunction

	pp_pkg::pp_ports_t latch_r;
	pp_pkg::pp_ports_t dir_r;
	pp_pkg::pp_ports_t fe_r;
	pp_pkg::pp_ports_t otype_r;
	pp_pkg::pp_ports_t pu_r;
	pp_pkg::pp_ports_t pinMeta_r;
	pp_pkg::pp_ports_t pinSync_r;
	logic [7:0]        serCfg_r;
	logic [7:0]        regRdata_nxt;
	logic [2:0]        slot;
	logic [2:0]        kind;
	logic              portSel;
	logic [1:0]        serFunc;
	logic              serLoc;
	logic              uartSwap;
	pp_pkg::pp_ports_t secVal;
	pp_pkg::pp_ports_t secDrv;
	pp_pkg::pp_ports_t forceOd;
	pp_pkg::pp_ports_t oscPins;
	pp_pkg::pp_ports_t odEff;

	assign slot     = regAddr[5:3];
	assign kind     = regAddr[2:0];
	assign portSel  = ~regAddr[6];
	assign serFunc  = serCfg_r[`PP_SER_FUNC_HI:`PP_SER_FUNC_LO];
	assign serLoc   = serCfg_r[`PP_SER_LOC];
	assign uartSwap = serCfg_r[`PP_SER_SWAP];

	////////////////////////////////////////////////////////////////
	// register writes; unimplemented bits stay zero
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			latch_r <= '0;
		end else if (regWr && portSel && kind == `PP_REG_LATCH) begin
			latch_r[slot] <= regWdata & slotMask(`PP_WIDTH_MASKS, slot); // see RULE2
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			dir_r <= '0; // see RULE17
			fe_r  <= '0; // see RULE17
		end else if (regWr && portSel) begin
			if (kind == `PP_REG_DIR)
				dir_r[slot] <= regWdata & slotMask(`PP_WIDTH_MASKS, slot); // see RULE8
			if (kind == `PP_REG_FE)
				fe_r[slot] <= regWdata & slotMask(`PP_FE_MASKS, slot); // see RULE9
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			otype_r  <= '0;
			pu_r     <= '0;
			serCfg_r <= `PP_RESET_BYTE;
		end else if (regWr) begin
			if (portSel && kind == `PP_REG_OTYPE)
				otype_r[slot] <= regWdata & slotMask(`PP_OTYPE_MASKS, slot); // see RULE10
			if (portSel && kind == `PP_REG_PULLUP)
				pu_r[slot] <= regWdata & slotMask(`PP_WIDTH_MASKS, slot); // see RULE11
			if (regAddr == `PP_ADDR_SERCFG)
				serCfg_r <= regWdata & `PP_SER_MASK;
		end
	end

	////////////////////////////////////////////////////////////////
	// two-flop synchroniser; nothing reads pinMeta_r but pinSync_r
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
		end else begin
			pinMeta_r <= padIn;
			pinSync_r <= pinMeta_r;
		end
	end

	// live level, no latch or filter; chatter is software's problem
	always_comb begin
		regRdata_nxt = '0;
		if (regRd && portSel) begin
			case (kind)
				`PP_REG_LATCH:  regRdata_nxt = latch_r[slot];
				`PP_REG_PINRD:  regRdata_nxt = pinSync_r[slot] & slotMask(`PP_WIDTH_MASKS, slot) & ~oscPins[slot]; // see RULE3 RULE4 RULE7
				`PP_REG_DIR:    regRdata_nxt = dir_r[slot];
				`PP_REG_FE:     regRdata_nxt = fe_r[slot];
				`PP_REG_OTYPE:  regRdata_nxt = otype_r[slot];
				`PP_REG_PULLUP: regRdata_nxt = pu_r[slot];
				default:        regRdata_nxt = '0;
			endcase
		end else if (regRd && regAddr == `PP_ADDR_SERCFG) begin
			regRdata_nxt = serCfg_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			regRdata <= '0;
		else
			regRdata <= regRdata_nxt;
	end

	////////////////////////////////////////////////////////////////
	// secondary output routing on port 2
	always_comb begin
		secVal  = '0;
		secDrv  = '0;
		forceOd = '0;
		if (!serFunc[0]) begin // see RULE15
			secVal[2][4]  = secOut.sclOut;
			secVal[2][3]  = secOut.sdaOut;
			secDrv[2][4]  = 1'b1;
			secDrv[2][3]  = 1'b1;
			forceOd[2][4] = 1'b1;
			forceOd[2][3] = 1'b1;
		end
		if (serFunc == 2'b01) begin // see RULE15
			secVal[2][5] = secOut.sclkOut;
			secDrv[2][5] = secOut.sclkDrv;
			secVal[2][3] = secOut.soOut;
			secDrv[2][3] = 1'b1;
		end
		if (serFunc == 2'b10 && !serLoc) begin // see RULE15
			secVal[2][2] = secOut.sclkOut;
			secDrv[2][2] = secOut.sclkDrv;
			secVal[2][0] = secOut.soOut;
			secDrv[2][0] = 1'b1;
		end
		if (!serFunc[1] && !serLoc) begin // see RULE16
			secVal[2][uartSwap ? 1 : 0] = secOut.uartTx;
			secDrv[2][uartSwap ? 1 : 0] = 1'b1;
		end
	end

	// fast pair always oscillator; slow pair handed over by its enable
	always_comb begin
		oscPins       = '0;
		oscPins[0][1:0] = 2'b11; // see RULE13
		oscPins[0][3:2] = {2{fe_r[0][`PP_BIT_SLOWOSC]}}; // see RULE12
	end

	assign fastOscEn = fe_r[`PP_SLOT_P0][`PP_BIT_FASTOSC]; // see RULE12
	assign slowOscEn = fe_r[`PP_SLOT_P0][`PP_BIT_SLOWOSC]; // see RULE12

	////////////////////////////////////////////////////////////////
	// pin drive: latch or peripheral, push-pull or open drain
	always_comb begin
		padOut = '0;
		padOe  = '0;
		padPu  = '0;
		odEff  = otype_r | forceOd;
		for (int p = 0; p < `PP_NPORT; p++) begin
			for (int b = 0; b < 8; b++) begin
				logic en;
				logic val;
				en  = dir_r[p][b] & ~oscPins[p][b] & (~fe_r[p][b] | secDrv[p][b]); // see RULE1 RULE8
				val = fe_r[p][b] ? secVal[p][b] : latch_r[p][b]; // see RULE6 RULE9
				if (odEff[p][b]) begin
					padOe[p][b] = en & ~val; // see RULE10
				end else begin
					padOe[p][b]  = en; // see RULE5
					padOut[p][b] = val;
				end
				padPu[p][b] = pu_r[p][b] & ~oscPins[p][b] & (~dir_r[p][b] | odEff[p][b]); // see RULE11
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// peripheral inputs; interrupt and stop inputs need input mode
	always_comb begin
		secIn             = '0;
		secIn.resetPin    = pinSync_r[1][0]; // see RULE14
		secIn.irqB        = pinSync_r[1][3] & ~dir_r[1][3]; // see RULE14
		secIn.irqA        = pinSync_r[1][2] & ~dir_r[1][2]; // see RULE14
		secIn.irqC        = pinSync_r[1][1] & ~dir_r[1][1]; // see RULE14
		secIn.stopRelease = pinSync_r[1][1] & ~dir_r[1][1]; // see RULE14
		secIn.sclIn       = ~serFunc[0] & pinSync_r[2][4];
		secIn.sdaIn       = ~serFunc[0] & pinSync_r[2][3];
		if (serFunc == 2'b01) begin // see RULE15
			secIn.sclkIn = pinSync_r[2][5];
			secIn.siIn   = pinSync_r[2][4];
		end else if (serFunc == 2'b10 && !serLoc) begin
			secIn.sclkIn = pinSync_r[2][2];
			secIn.siIn   = pinSync_r[2][1];
		end
		if (!serFunc[1] && !serLoc)
			secIn.uartRx = uartSwap ? pinSync_r[2][0] : pinSync_r[2][1]; // see RULE16
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence latchWrite2;
		regWr && portSel && kind == `PP_REG_LATCH && slot == 3'h2;
	endsequence

	latch_write_a: assert property (latchWrite2 |=> latch_r[2] == $past(regWdata)) // see RULE2
		else $error("latch did not take written value");
	latch_hold_a: assert property (!(regWr && portSel && kind == `PP_REG_LATCH)
		|=> latch_r == $past(latch_r)) // see RULE2
		else $error("latch changed without write");
	pin_read_a: assert property (regRd && portSel && kind == `PP_REG_PINRD && slot == 3'h2
		|=> regRdata == $past(pinSync_r[2])) // see RULE4
		else $error("pin read not sampled in read cycle");
	// two-wire pins are forced open drain, so the check needs function select bit0 set
	out_follow_a: assert property ((latchWrite2 and (dir_r[2] == 8'hff // see RULE5
		&& fe_r[2] == 8'h00 && otype_r[2] == 8'h00 && serFunc[0]))
		##1 $stable(dir_r[2]) |-> padOut[2] == $past(regWdata))
		else $error("written value not on pins next cycle");
	osc_pins_a: assert property (padOe[0][1:0] == 2'b00 && padPu[0][1:0] == 2'b00) // see RULE13
		else $error("fast oscillator pin driven");
	od_low_a: assert property ((padOe & padOut & odEff) == '0) // see RULE10
		else $error("open drain pin driven high");
	pullup_a: assert property ((padPu & dir_r & ~odEff) == '0) // see RULE11
		else $error("pull-up on push-pull output");
	irq_gate_a: assert property (dir_r[1][2] |-> !secIn.irqA) // see RULE14
		else $error("interrupt passed in output mode");
	uart_swap_a: assert property (!serFunc[1] && !serLoc && uartSwap && dir_r[2][1]
		&& fe_r[2][1] && !otype_r[2][1] |-> padOe[2][1] && padOut[2][1] == secOut.uartTx) // see RULE16
		else $error("uart transmit on wrong pin");

	////////////////////////////////////////////////////////////////
	// reset check must not be switched off by the reset it watches
	reset_idle_a: assert property (disable iff (1'b0) !nrst |=> padOe == '0 // see RULE17
		&& padPu == '0 && !fastOscEn && !slowOscEn)
		else $error("pins not idle after reset");
	rd_idle_a: assert property (!regRd |=> regRdata == 8'h00) // see RULE7
		else $error("read data outside read answer cycle");
	pp_drive_a: assert property (dir_r[2][6] && !fe_r[2][6] && !otype_r[2][6] // see RULE6
		|-> padOe[2][6] && padOut[2][6] == latch_r[2][6])
		else $error("output pin not driven from latch");
	slow_osc_a: assert property (fe_r[0][2] // see RULE12
		|-> padOe[0][3:2] == 2'b00 && padPu[0][3:2] == 2'b00)
		else $error("slow oscillator pin driven");
	twowire_od_a: assert property (!serFunc[0] && dir_r[2][4] && fe_r[2][4] // see RULE15
		|-> !padOut[2][4] && padOe[2][4] == !secOut.sclOut)
		else $error("two-wire clock pin not open drain");

endmodule

`default_nettype wire

// File: tb/pp_pin_model.sv
// board-side model of the pads: device drive, pull-up and outside sources
// assumes the bench sets extDrv and extEn per pin
`timescale 1ns/1ps
`default_nettype none

module pp_pin_model (
	input  wire pp_pkg::pp_ports_t padOut,
	input  wire pp_pkg::pp_ports_t padOe,
	input  wire pp_pkg::pp_ports_t padPu,
	input  wire pp_pkg::pp_ports_t extDrv,
	input  wire pp_pkg::pp_ports_t extEn,
	output pp_pkg::pp_ports_t      padIn
);
	// floating pins show the inverse of padOut, so a stale level is never read back
	assign padIn = (padOe & padOut) | (~padOe & extEn & extDrv)
		| (~padOe & ~extEn & padPu)
		| (~padOe & ~extEn & ~padPu & ~padOut);
endmodule

`default_nettype wire

// File: tb/tb_parallel_port_pin_control.sv
// self-checking bench for the port pin control block
// assumes the pin model resolves pads; bus driven on rising edges
`timescale 1ns/1ps
`default_nettype none

module tb_parallel_port_pin_control;
	logic                sys_clk = 1'b0;
	logic                nrst = 1'b0;
	logic [6:0]          regAddr = 7'h00;
	logic [7:0]          regWdata = 8'h00;
	logic                regWr = 1'b0;
	logic                regRd = 1'b0;
	logic [7:0]          regRdata;
	pp_pkg::pp_ports_t   padIn, padOut, padOe, padPu;
	pp_pkg::pp_ports_t   extDrv = '0;
	pp_pkg::pp_ports_t   extEn = '0;
	pp_pkg::pp_sec_out_t secOut = '0;
	pp_pkg::pp_sec_in_t  secIn;
	logic                fastOscEn, slowOscEn;
	int                  numErrors = 0;
	int                  nCompared = 0;

	always #12.5 sys_clk = ~sys_clk;

	pp_port_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.padIn(padIn), .padOut(padOut), .padOe(padOe), .padPu(padPu),
		.secOut(secOut), .secIn(secIn), .fastOscEn(fastOscEn), .slowOscEn(slowOscEn));
	pp_pin_model pins (.padOut(padOut), .padOe(padOe), .padPu(padPu),
		.extDrv(extDrv), .extEn(extEn), .padIn(padIn));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
		nCompared++;
		if (seen !== exp) begin
			numErrors++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic rdChk(input logic [6:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		chk(regRdata, exp, "read data");
	endtask

	task automatic ext(input logic [2:0] s, input logic [7:0] d);
		@(posedge sys_clk);
		extDrv[s] <= d;
		extEn[s] <= 8'hff;
		cyc(3);
	endtask

	task automatic completeRun();
		if (numErrors == 0 && nCompared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic testReset();
		chk(padOe, '0, "reset drive");
		chk(padPu, '0, "reset pull-up");
		chk({fastOscEn, slowOscEn}, 2'b00, "reset osc");
		rdChk(7'h12, 8'h00);
	endtask

	task automatic testOutput();
		wr(7'h40, 8'h01);
		wr(7'h12, 8'hff);
		wr(7'h10, 8'ha5);
		chk({padOut[2], padOe[2]}, 16'ha5ff, "push-pull drive");
		wr(7'h15, 8'hff);
		chk({padOut[2], padPu[2]}, 16'ha500, "latch held");
		wr(7'h2a, 8'hff);
		chk(padOe[5], 8'h03, "narrow port");
	endtask

	task automatic testOpenDrain();
		wr(7'h14, 8'hff);
		chk({padOe[2], padPu[2]}, 16'h5aff, "open drain");
		wr(7'h14, 8'h00);
	endtask

	task automatic testInput();
		ext(3'h3, 8'h3c);
		rdChk(7'h19, 8'h3c);
		ext(3'h3, 8'hc3);
		rdChk(7'h19, 8'hc3);
		wr(7'h1d, 8'hff);
		chk(padPu[3], 8'hff, "input pull-up");
	endtask

	task automatic testOsc();
		wr(7'h02, 8'h0f);
		wr(7'h00, 8'h0f);
		chk(padOe[0], 8'h0c, "fast osc pins idle");
		wr(7'h03, 8'h04);
		chk({slowOscEn, fastOscEn, padOe[0]}, 10'h200, "slow osc");
		wr(7'h03, 8'h05);
		chk(fastOscEn, 1'b1, "fast osc");
	endtask

	task automatic testIrq();
		ext(3'h1, 8'h06);
		chk({secIn.irqA, secIn.irqB, secIn.irqC, secIn.resetPin}, 4'ha, "p1 inputs");
		wr(7'h0a, 8'h04);
		cyc(3);
		chk(secIn.irqA, 1'b0, "irq in output mode");
	endtask

	task automatic testUart();
		wr(7'h10, 8'h00);
		wr(7'h13, 8'h03);
		@(posedge sys_clk);
		secOut.uartTx <= 1'b1;
		cyc(1);
		chk({padOut[2][0], padOe[2][0]}, 2'b11, "tx on bit0");
		wr(7'h40, 8'h09);
		chk({padOut[2][1:0], padOe[2][1]}, 3'b101, "tx swapped");
		wr(7'h40, 8'h0d);
		chk(padOe[2][1:0], 2'b00, "other location");
		rdChk(7'h7f, 8'h00);
	endtask

	task automatic testSerial();
		wr(7'h13, 8'h18);
		wr(7'h40, 8'h00);
		@(posedge sys_clk);
		secOut.sclOut <= 1'b0;
		secOut.sdaOut <= 1'b1;
		cyc(3);
		chk({padOe[2][4:3], padPu[2][4:3]}, 4'b1011, "two-wire open drain");
		chk({secIn.sclIn, secIn.sdaIn}, 2'b01, "two-wire inputs");
		wr(7'h40, 8'h01);
		wr(7'h13, 8'h28);
		wr(7'h10, 8'h02);
		@(posedge sys_clk);
		secOut.sclkOut <= 1'b1;
		secOut.sclkDrv <= 1'b1;
		secOut.soOut <= 1'b1;
		cyc(3);
		chk({padOut[2][5], padOe[2][5]}, 2'b11, "serial clock out");
		chk({padOut[2][3], padOe[2][3]}, 2'b11, "serial data out");
		chk(secIn.uartRx, 1'b1, "rx on bit1");
	endtask

	task automatic testMidReset();
		@(posedge sys_clk);
		nrst <= 1'b0;
		cyc(2);
		@(posedge sys_clk);
		nrst <= 1'b1;
		cyc(1);
		chk(padOe, '0, "mid-run reset drive");
		chk(padPu, '0, "mid-run reset pull-up");
		chk({fastOscEn, slowOscEn}, 2'b00, "mid-run reset osc");
		rdChk(7'h40, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(3);
		@(posedge sys_clk);
		nrst <= 1'b1;
		cyc(1);
		testReset();
		testOutput();
		testOpenDrain();
		testInput();
		testOsc();
		testIrq();
		testUart();
		testSerial();
		testMidReset();
		completeRun();
	end
endmodule

`default_nettype wire
